// File: strap_config_select.sv
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1 - Select input high: serial registers configure
// RULE2 - Select low: straps win, writes ignored
// RULE3 - De-emphasis strap: low 2 dB, open 0 dB
// RULE4 - EQ strap: low 7.5, open adaptive, high 14
// RULE5 - Serial mode: EQ strap is address bit
// RULE6 - EQ strap three-level; two-level as address
// RULE7 - Sink strap high selects DVI-type output
// RULE8 - Non-DVI sink exposes adaptor identification block
// RULE9 - Serial mode: sink strap is address bit
// RULE10 - Termination strap high: termination off
// RULE11 - Termination strap low: 75-150 ohm on
// RULE12 - Termination open: chosen from link rate
// RULE13 - Lane strap high: invert polarity, retimer only
// RULE14 - Lane strap low: swap lane order
// RULE15 - Lane strap open: normal lanes
// RULE16 - Three-level straps resolve to stable codes
module strap_config_select
    import strap_cfg_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              serial_mode_select,
    input  wire logic              deemph_strap_above,
    input  wire logic              deemph_strap_below,
    input  wire logic              equalizer_strap_addr_lo_above,
    input  wire logic              equalizer_strap_addr_lo_below,
    input  wire logic              transmit_termination_strap_above,
    input  wire logic              transmit_termination_strap_below,
    input  wire logic              lane_order_strap_above,
    input  wire logic              lane_order_strap_below,
    input  wire logic              sink_type_strap_addr_hi,
    input  wire logic [RATE_W-1:0] link_data_rate,
    input  wire logic              retimer_active,
    output var  logic              deemph_2db,
    output var  eq_t               eq_mode,
    output var  term_t             term_sel,
    output var  logic              lane_swap,
    output var  logic              lane_invert,
    output var  logic              dvi_mode,
    output var  logic              adaptor_id_visible,
    output var  logic [1:0]        slave_addr_bits
);

    logic [N_STRAPS-1:0] pin_above;
    logic [N_STRAPS-1:0] pin_below;
    level_t              lvl [N_STRAPS];
    logic                serial;

    // Two-level pins reuse the resolver with complementary comparators
    assign pin_above = {serial_mode_select, sink_type_strap_addr_hi,
                        lane_order_strap_above,
                        transmit_termination_strap_above,
                        equalizer_strap_addr_lo_above,
                        deemph_strap_above};
    assign pin_below = {~serial_mode_select, ~sink_type_strap_addr_hi,
                        lane_order_strap_below,
                        transmit_termination_strap_below,
                        equalizer_strap_addr_lo_below,
                        deemph_strap_below};

    strap_code_if strap [N_STRAPS] ();

    genvar gi;
    generate
        for (gi = 0; gi < N_STRAPS; gi++) begin : g_strap
            strap_resolver u_res (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .pin_above (pin_above[gi]),
                .pin_below (pin_below[gi]),
                .out       (strap[gi])
            );
            assign lvl[gi] = strap[gi].code;
        end
    endgenerate

    assign serial = (lvl[STRAP_MODE] == LVL_HIGH);

    // Bus state
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0]        wr_byte;
    logic              wr_lane0;
    ctrl_t             ctrl;
    status_t           status;
    logic              next_aw_held;
    logic              next_w_held;
    logic [ADDR_W-1:0] next_wr_addr;
    logic [7:0]        next_wr_byte;
    logic              next_wr_lane0;
    ctrl_t             next_ctrl;
    logic              next_awready;
    logic              next_wready;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_arready;
    logic              next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;

    // Address and data are taken independently, then joined
    always_comb begin
        next_aw_held  = aw_held;
        next_w_held   = w_held;
        next_wr_addr  = wr_addr;
        next_wr_byte  = wr_byte;
        next_wr_lane0 = wr_lane0;
        next_ctrl     = ctrl;
        next_bvalid   = s_axi_bvalid;
        next_bresp    = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_wr_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held   = 1'b1;
            next_wr_byte  = s_axi_wdata[7:0];
            next_wr_lane0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            if (wr_addr[3:2] == CTRL_ADDR[3:2]) begin
                // Straps own the settings in pin mode
                if (serial && wr_lane0) // [RULE2]
                    next_ctrl = ctrl_t'(wr_byte);
            end else if (wr_addr[3:2] != STAT_ADDR[3:2]) begin
                next_bresp = RESP_SLVERR;
            end
        end
        // No new request while a response waits
        next_awready = !next_aw_held && !next_bvalid;
        next_wready  = !next_w_held && !next_bvalid;
    end

    // Read path answers one cycle after the address is taken
    always_comb begin
        next_arready = s_axi_arready;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = RESP_OKAY;
            next_rdata   = 32'h0;
            if (s_axi_araddr[3:2] == CTRL_ADDR[3:2])
                next_rdata[7:0] = ctrl;
            else if (s_axi_araddr[3:2] == STAT_ADDR[3:2])
                next_rdata[12:0] = status;
            else
                next_rresp = RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_arready = 1'b1;
            next_rvalid  = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            wr_addr       <= 4'h0;
            wr_byte       <= 8'h00;
            wr_lane0      <= 1'b0;
            ctrl          <= ctrl_t'(CTRL_RESET);
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            wr_addr       <= next_wr_addr;
            wr_byte       <= next_wr_byte;
            wr_lane0      <= next_wr_lane0;
            ctrl          <= next_ctrl;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // Effective configuration
    logic       next_deemph;
    eq_t        next_eq;
    term_t      next_term;
    logic       next_swap;
    logic       next_invert;
    logic       next_dvi;
    logic       next_adaptor;
    logic [1:0] next_addr;

    always_comb begin
        next_deemph = DEEMPH_0DB;
        next_eq     = EQ_ADAPTIVE;
        next_term   = term_from_rate(link_data_rate);
        next_swap   = 1'b0;
        next_invert = 1'b0;
        next_addr   = 2'h0;
        if (serial) begin // [RULE1]
            next_deemph = ctrl.deemph;
            next_eq     = ctrl.eq;
            case (ctrl.term)
                TMODE_ON:  next_term = TERM_75_150;
                TMODE_OFF: next_term = TERM_NONE;
                default:   next_term = term_from_rate(link_data_rate);
            endcase
            next_swap   = (ctrl.lane == LANE_SWAP);
            next_invert = (ctrl.lane == LANE_INVERT) && retimer_active;
            next_dvi    = ctrl.dvi;
            // Address pins read as plain two-level inputs
            next_addr   = {lvl[STRAP_SINK] == LVL_HIGH, // [RULE9]
                           lvl[STRAP_EQ] == LVL_HIGH};  // [RULE5] [RULE6]
        end else begin
            // Reserved high level falls back to 0 dB
            if (lvl[STRAP_DEEMPH] == LVL_LOW) // [RULE3]
                next_deemph = DEEMPH_2DB;
            case (lvl[STRAP_EQ]) // [RULE4] [RULE6]
                LVL_LOW:  next_eq = EQ_FIXED_LO;
                LVL_HIGH: next_eq = EQ_FIXED_HI;
                default:  next_eq = EQ_ADAPTIVE;
            endcase
            case (lvl[STRAP_TERM]) // [RULE12]
                LVL_HIGH: next_term = TERM_NONE;   // [RULE10]
                LVL_LOW:  next_term = TERM_75_150; // [RULE11]
                default:  next_term = term_from_rate(link_data_rate);
            endcase
            case (lvl[STRAP_LANE])
                LVL_LOW:  next_swap = 1'b1; // [RULE14]
                LVL_HIGH: next_invert = retimer_active; // [RULE13]
                default:  next_swap = 1'b0; // [RULE15]
            endcase
            next_dvi = (lvl[STRAP_SINK] == LVL_HIGH); // [RULE7]
        end
        next_adaptor = !next_dvi; // [RULE8]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            deemph_2db         <= DEEMPH_0DB;
            eq_mode            <= EQ_ADAPTIVE;
            term_sel           <= TERM_NONE;
            lane_swap          <= 1'b0;
            lane_invert        <= 1'b0;
            dvi_mode           <= 1'b0;
            adaptor_id_visible <= 1'b1; // Non-DVI after reset, as dvi_mode
            slave_addr_bits    <= 2'h0;
        end else begin
            deemph_2db         <= next_deemph;
            eq_mode            <= next_eq;
            term_sel           <= next_term;
            lane_swap          <= next_swap;
            lane_invert        <= next_invert;
            dvi_mode           <= next_dvi;
            adaptor_id_visible <= next_adaptor;
            slave_addr_bits    <= next_addr;
        end
    end

    // Status reflects the registered outputs, the mode strap and the reserved de-emphasis level
    assign status = '{deemph_rsvd: !serial &&
                                    lvl[STRAP_DEEMPH] == LVL_HIGH,
                      addr_bits:  slave_addr_bits,
                      adaptor_id: adaptor_id_visible,
                      dvi:        dvi_mode,
                      invert:     lane_invert,
                      swap:       lane_swap,
                      term:       term_sel,
                      eq:         eq_mode,
                      deemph:     deemph_2db,
                      serial:     serial};

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_joined;
        aw_held && w_held && !s_axi_bvalid;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_write_answer: assert property (s_write_joined |=> s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
        else $error("read response missing");

    a_serial_eq_reg: assert property ( // [RULE1]
        serial |=> eq_mode == $past(ctrl.eq))
        else $error("serial mode ignores control register");
    a_pin_write_blk: assert property ( // [RULE2]
        (!serial) and s_write_joined |=> ctrl == $past(ctrl))
        else $error("write altered control in pin mode");
    a_pin_deemph_map: assert property ( // [RULE3]
        !serial |=> deemph_2db == ($past(lvl[STRAP_DEEMPH]) == LVL_LOW))
        else $error("de-emphasis strap decode wrong");
    a_pin_eq_map: assert property ( // [RULE4]
        !serial && lvl[STRAP_EQ] == LVL_HIGH |=> eq_mode == EQ_FIXED_HI)
        else $error("equalizer strap decode wrong");
    a_addr_bits: assert property ( // [RULE5] [RULE9]
        serial |=> slave_addr_bits ==
            {$past(lvl[STRAP_SINK]) == LVL_HIGH,
             $past(lvl[STRAP_EQ]) == LVL_HIGH})
        else $error("slave address bits wrong");
    a_sink_dvi: assert property ( // [RULE7]
        !serial |=> dvi_mode == ($past(lvl[STRAP_SINK]) == LVL_HIGH))
        else $error("sink type decode wrong");
    a_adaptor_id: assert property ( // [RULE8]
        adaptor_id_visible == !dvi_mode)
        else $error("adaptor id visibility wrong");
    a_term_fixed: assert property ( // [RULE10] [RULE11]
        !serial && lvl[STRAP_TERM] != LVL_OPEN |=>
            term_sel == ($past(lvl[STRAP_TERM]) == LVL_LOW ?
                         TERM_75_150 : TERM_NONE))
        else $error("fixed termination decode wrong");
    a_term_auto: assert property ( // [RULE12]
        !serial && lvl[STRAP_TERM] == LVL_OPEN |=>
            term_sel == term_from_rate($past(link_data_rate)))
        else $error("automatic termination wrong");
    a_lane_map: assert property ( // [RULE13] [RULE14] [RULE15]
        !serial |=> lane_swap == ($past(lvl[STRAP_LANE]) == LVL_LOW) &&
            lane_invert == ($past(lvl[STRAP_LANE]) == LVL_HIGH &&
                            $past(retimer_active)))
        else $error("lane order decode wrong");

endmodule
`default_nettype wire

// File: strap_cfg_pkg.sv
package strap_cfg_pkg;

    // Resolved level of a strap pin
    typedef enum logic [1:0] {
        LVL_LOW  = 2'b00,
        LVL_OPEN = 2'b01,
        LVL_HIGH = 2'b10
    } level_t;

    typedef enum logic [1:0] {
        EQ_FIXED_LO = 2'b00,
        EQ_ADAPTIVE = 2'b01,
        EQ_FIXED_HI = 2'b10
    } eq_t;

    typedef enum logic [1:0] {
        TERM_NONE    = 2'b00,
        TERM_75_150  = 2'b01,
        TERM_150_300 = 2'b10
    } term_t;

    typedef enum logic [1:0] {
        TMODE_AUTO = 2'b00,
        TMODE_ON   = 2'b01,
        TMODE_OFF  = 2'b10
    } term_mode_t;

    typedef enum logic [1:0] {
        LANE_NORMAL = 2'b00,
        LANE_SWAP   = 2'b01,
        LANE_INVERT = 2'b10
    } lane_mode_t;

    // Control word, low byte of the control register
    typedef struct packed {
        logic       dvi;
        lane_mode_t lane;
        term_mode_t term;
        eq_t        eq;
        logic       deemph;
    } ctrl_t;

    // Status word, low bits of the status register
    typedef struct packed {
        logic       deemph_rsvd;
        logic [1:0] addr_bits;
        logic       adaptor_id;
        logic       dvi;
        logic       invert;
        logic       swap;
        term_t      term;
        eq_t        eq;
        logic       deemph;
        logic       serial;
    } status_t;

    localparam int         ADDR_W     = 4;
    localparam logic [3:0] CTRL_ADDR  = 4'h0;
    localparam logic [3:0] STAT_ADDR  = 4'h4;
    localparam logic [7:0] CTRL_RESET = 8'h02;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic       DEEMPH_0DB = 1'b0;
    localparam logic       DEEMPH_2DB = 1'b1;

    // Link rate in units of 10 Mbps
    localparam int          RATE_W      = 10;
    localparam logic [9:0]  RATE_HI_MIN = 10'h154;
    localparam logic [9:0]  RATE_LO_MIN = 10'h0c8;

    // Strap slots
    localparam int STRAP_DEEMPH = 0;
    localparam int STRAP_EQ     = 1;
    localparam int STRAP_TERM   = 2;
    localparam int STRAP_LANE   = 3;
    localparam int STRAP_SINK   = 4;
    localparam int STRAP_MODE   = 5;
    localparam int N_STRAPS     = 6;

    // Automatic termination from the link rate
    function automatic term_t term_from_rate(input logic [9:0] rate);
        if (rate > RATE_HI_MIN)
            return TERM_75_150;
        else if (rate > RATE_LO_MIN)
            return TERM_150_300;
        else
            return TERM_NONE;
    endfunction

endpackage

// File: strap_code_if.sv
`timescale 1ns/1ps
`default_nettype none
interface strap_code_if;
    import strap_cfg_pkg::*;
    level_t code;
    modport drive (output code);
    modport sink  (input code);
endinterface
`default_nettype wire

// File: strap_resolver.sv
`timescale 1ns/1ps
`default_nettype none
module strap_resolver
    import strap_cfg_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         pin_above,
    input  wire logic         pin_below,
    strap_code_if.drive       out
);

    logic [2:0] sync_above;
    logic [2:0] sync_below;
    logic [2:0] next_sync_above;
    logic [2:0] next_sync_below;
    level_t     code;
    level_t     next_code;

    // Only stages two and three are compared; stage one feeds stage two
    always_comb begin
        next_sync_above = {sync_above[1:0], pin_above};
        next_sync_below = {sync_below[1:0], pin_below};
        next_code       = code;
        if (sync_above[2] == sync_above[1] &&
            sync_below[2] == sync_below[1]) begin
            case ({sync_above[1], sync_below[1]}) // [RULE16]
                2'b01:   next_code = LVL_LOW;
                2'b10:   next_code = LVL_HIGH;
                2'b00:   next_code = LVL_OPEN;
                default: next_code = code; // Both comparators: glitch
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_above <= 3'h0;
            sync_below <= 3'h0;
            code       <= LVL_OPEN;
        end else begin
            sync_above <= next_sync_above;
            sync_below <= next_sync_below;
            code       <= next_code;
        end
    end

    assign out.code = code;

    a_code_low_agree: assert property ( // [RULE16]
        @(posedge aclk) disable iff (!aresetn)
        sync_below[2:1] == 2'h3 && sync_above[2:1] == 2'h0
        |=> code == LVL_LOW)
        else $error("strap code did not settle low");

    a_code_held: assert property ( // [RULE16]
        @(posedge aclk) disable iff (!aresetn)
        sync_above[2] != sync_above[1] |=> $stable(code))
        else $error("strap code moved while inputs disagree");

endmodule
`default_nettype wire

// File: strap_board.sv
`timescale 1ns/1ps
`default_nettype none
// Board strap network: a resistor to a rail, or nothing fitted
module strap_board
    import strap_cfg_pkg::*;
(
    input  var level_t     lvl [4],
    output var logic [3:0] above,
    output var logic [3:0] below
);
    // Open pin floats mid-rail, so neither comparator trips
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            above[i] = (lvl[i] == LVL_HIGH);
            below[i] = (lvl[i] == LVL_LOW);
        end
    end
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import strap_cfg_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
    logic        awready, wready, bvalid, arready, rvalid, mode, sink, retimer;
    logic        d2, swp, inv, dvi, adid;
    logic [1:0]  bresp, rresp, ad;
    logic [3:0]  awaddr, araddr, above, below;
    logic [31:0] wdata, rdata;
    logic [9:0]  rate;
    logic [7:0]  c;
    eq_t         eqm;
    term_t       trm;
    level_t      lv;
    level_t      lvl [4];
    logic [33:0] rq [$];
    logic [1:0]  bq [$];
    logic [9:0]  rates [4] = '{10'h0c8, 10'h0c9, 10'h154, 10'h155};
    int          n_mismatch, n_checks, seed;

    strap_board board (.lvl(lvl), .above(above), .below(below));

    strap_config_select DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serial_mode_select(mode),
        .deemph_strap_above(above[0]), .deemph_strap_below(below[0]),
        .equalizer_strap_addr_lo_above(above[1]),
        .equalizer_strap_addr_lo_below(below[1]),
        .transmit_termination_strap_above(above[2]),
        .transmit_termination_strap_below(below[2]),
        .lane_order_strap_above(above[3]), .lane_order_strap_below(below[3]),
        .sink_type_strap_addr_hi(sink), .link_data_rate(rate),
        .retimer_active(retimer), .deemph_2db(d2), .eq_mode(eqm),
        .term_sel(trm), .lane_swap(swp), .lane_invert(inv), .dvi_mode(dvi),
        .adaptor_id_visible(adid), .slave_addr_bits(ad));

    // 20 MHz clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic chk(string nm, logic [33:0] seen, logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Address and data offered together, each released once taken
    task automatic axi_wr(logic [3:0] a, logic [31:0] d, logic [1:0] r);
        bq.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid) @(posedge aclk);
    endtask

    task automatic axi_rd(logic [3:0] a, logic [33:0] e);
        rq.push_back(e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
    endtask

    // Responses are matched in order against the noted expectations
    always @(posedge aclk) begin
        if (bvalid && bready)
            chk("bresp", 34'(bresp), 34'(bq.pop_front()));
        if (rvalid && rready)
            chk("read", {rresp, rdata}, rq.pop_front());
    end

    function automatic term_t auto_term(logic [9:0] r);
        if (r > RATE_HI_MIN) return TERM_75_150;
        if (r > RATE_LO_MIN) return TERM_150_300;
        return TERM_NONE;
    endfunction

    task automatic cfg(logic d, eq_t e, term_t t, logic [2:0] l, logic [1:0] a);
        chk("deemph", 34'(d2), 34'(d));
        chk("eq", 34'(eqm), 34'(e));
        chk("term", 34'(trm), 34'(t));
        chk("lanes", 34'({swp, inv}), 34'(l[2:1]));
        chk("sink", 34'({dvi, adid}), 34'({l[0], !l[0]}));
        chk("addr", 34'(ad), 34'(a));
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        seed = 13087;
        {awvalid, wvalid, arvalid, mode, sink, retimer} = 6'h00;
        {awaddr, araddr, wdata, rate} = '0;
        {bready, rready, aresetn} = 3'h6;
        lvl = '{default: LVL_OPEN};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        // Pin mode: every level of each three-level strap, rates at the thresholds
        for (int k = 0; k < 12; k++) begin
            lv = level_t'(k % 3);
            @(posedge aclk);
            lvl <= '{lv, lv, lv, lv};
            sink <= 1'($random(seed));
            retimer <= 1'($random(seed));
            rate <= rates[k / 3];
            axi_wr(CTRL_ADDR, 32'h000000a9, RESP_OKAY);
            repeat (8) @(posedge aclk);
            cfg(lv == LVL_LOW, lv == LVL_LOW ? EQ_FIXED_LO :
                lv == LVL_HIGH ? EQ_FIXED_HI : EQ_ADAPTIVE,
                lv == LVL_LOW ? TERM_75_150 : lv == LVL_HIGH ? TERM_NONE :
                auto_term(rate),
                {lv == LVL_LOW, lv == LVL_HIGH && retimer, sink}, 2'b00);
        end
        axi_rd(CTRL_ADDR, 34'(CTRL_RESET));
        // Serial mode: register decides, straps become address bits
        @(posedge aclk);
        mode <= 1'b1;
        repeat (8) @(posedge aclk);
        for (int k = 0; k < 9; k++) begin
            c = 8'($random(seed));
            c[2:1] = 2'(k % 3);
            c[4:3] = 2'((k / 3) % 3);
            if (c[6:5] == 2'h3) c[6:5] = 2'h2;
            @(posedge aclk);
            lvl[1] <= level_t'(k % 3);
            sink <= 1'($random(seed));
            retimer <= 1'($random(seed));
            rate <= rates[k % 4];
            axi_wr(CTRL_ADDR, {24'h0, c}, RESP_OKAY);
            repeat (8) @(posedge aclk);
            cfg(c[0], eq_t'(c[2:1]), c[4:3] == 2'h1 ? TERM_75_150 :
                c[4:3] == 2'h2 ? TERM_NONE : auto_term(rate),
                {c[6:5] == 2'h1, c[6:5] == 2'h2 && retimer, c[7]},
                {sink, lvl[1] == LVL_HIGH});
            axi_rd(CTRL_ADDR, 34'(c));
        end
        axi_wr(STAT_ADDR, 32'h00000000, RESP_OKAY);
        axi_wr(4'hc, 32'h00000001, RESP_SLVERR);
        axi_rd(4'h8, {RESP_SLVERR, 32'h0});
        // Back to pin mode: straps take over again
        @(posedge aclk);
        mode <= 1'b0;
        lvl <= '{default: LVL_LOW};
        repeat (8) @(posedge aclk);
        cfg(1'b1, EQ_FIXED_LO, TERM_75_150, {2'b10, sink}, 2'b00);
        axi_rd(STAT_ADDR, 34'({!sink, sink, 8'h52}));
        repeat (4) @(posedge aclk);
        complete_run();
    end
endmodule
`default_nettype wire
